/* hw/palette_pkg.sv */
// shared constants and types for the palette host port and pixel path
package palette_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [23:0] entry_t;
  typedef logic [4:0]  weight_t;

  // register select codes {high, low}
  localparam logic [1:0] RS_PTR_WR = 2'h0;
  localparam logic [1:0] RS_COLOR  = 2'h1;
  localparam logic [1:0] RS_MASK   = 2'h2;
  localparam logic [1:0] RS_PTR_RD = 2'h3;

  // color phase counter values
  localparam logic [1:0] PH_RED   = 2'h0;
  localparam logic [1:0] PH_GREEN = 2'h1;
  localparam logic [1:0] PH_BLUE  = 2'h2;

  localparam byte_t   MASK_RESET  = 8'hFF;
  localparam byte_t   PTR_RESET   = 8'h00;
  localparam byte_t   SIX_BIT_MSK = 8'h3F;

  // mode entry: this many mask reads, then a mask write carries mode bits
  localparam logic [2:0] MODE_KEY_READS = 3'h4;
  localparam int      MODE_BLEND_BIT = 0;
  localparam int      MODE_REPL_BIT  = 1;
  localparam int      MODE_ENC_LSB   = 2;

  typedef enum logic [1:0] {ENC_BASIC8, ENC_ADV4, ENC_ADV8} enc_t;

  // blend arithmetic
  localparam weight_t    WEIGHT_FULL = 5'h1F;
  localparam logic [13:0] MIX_ROUND  = 14'h0010;
  localparam byte_t   ADV8_CMD_IDX   = 8'hDF;
  localparam byte_t   ADV8_MIX_BASE  = 8'hE0;

  // gamma curve knees
  localparam byte_t   GAMMA_KNEE_LO = 8'h40;
  localparam byte_t   GAMMA_KNEE_HI = 8'hC0;
  localparam byte_t   GAMMA_OFFSET  = 8'h60;

  // host controller registers (byte addresses)
  localparam logic [11:0] HOST_CMD_OFS    = 12'h000;
  localparam logic [11:0] HOST_STATUS_OFS = 12'h004;
  localparam logic [11:0] HOST_PIXEL_OFS  = 12'h008;
  localparam int      CMD_RS_LOW_BIT  = 8;
  localparam int      CMD_RS_HIGH_BIT = 9;
  localparam int      CMD_READ_BIT    = 10;
  localparam int      PIX_BLANK_BIT   = 8;
  localparam int      PIX_SYNC_BIT    = 9;

  // strobe low time: 50 ns at 25 ns per cycle
  localparam int      CLOCK_PERIOD_NS = 25;
  localparam int      STROBE_LOW_NS   = 50;
  localparam logic [1:0] STROBE_CYCLES =
    2'((STROBE_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
endpackage : palette_pkg

/* hw/palette_link_if.sv */
// link between host processor end and palette device end
`timescale 1ns/100ps
`default_nettype none
interface palette_link_if;
  logic       reg_select_low;
  logic       reg_select_high;
  logic       wr_n;
  logic       rd_n;
  logic [7:0] host_data_out;
  logic       host_data_oe_n;
  logic [7:0] dev_data_out;
  logic       dev_data_oe_n;
  logic [7:0] host_data_bus;
  logic [7:0] pixel_index_in;
  logic       blank_n;
  logic       sync_n;

  // resolved bus level; undriven bus reads as pulled high
  assign host_data_bus = !dev_data_oe_n ? dev_data_out :
                         (!host_data_oe_n ? host_data_out : 8'hFF);

  modport device (input reg_select_low, reg_select_high, wr_n, rd_n, host_data_bus,
                  pixel_index_in, blank_n, sync_n, output dev_data_out, dev_data_oe_n);
  modport host (input host_data_bus, output reg_select_low, reg_select_high, wr_n, rd_n,
                host_data_out, host_data_oe_n, pixel_index_in, blank_n, sync_n);
endinterface : palette_link_if
`default_nettype wire

/* hw/palette_host_end.sv */
// host end: APB registers turned into palette bus cycles and pixel drive
`timescale 1ns/100ps
`default_nettype none
module palette_host_end (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // apb slave
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // link
  palette_link_if.host       link
);
  import palette_pkg::*;

  typedef enum {H_IDLE, H_SETUP, H_STROBE, H_HOLD} hstate_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [10:0] cmd;
    byte_t       rd_data;
    byte_t       pix;
    logic        blank_n;
    logic        sync_n;
    hstate_t     st;
    logic [1:0]  cnt;
    logic        wr_n;
    logic        rd_n;
    logic [1:0]  rs;
    byte_t       dout;
    logic        oe_n;
  } host_state_t;

  host_state_t s;
  host_state_t n;
  logic        access;

  always_comb begin
    n = s;
    access = psel & penable & !s.pready;
    n.pready = access;
    n.pslverr = 1'b0;
    if (access) begin
      n.prdata = 32'h0000_0000;
      unique case (paddr)
        HOST_CMD_OFS: begin
          n.prdata = {21'h0, s.cmd};
          if (pwrite && s.st != H_IDLE) begin
            // busy: command refused
            n.pslverr = 1'b1;
          end else if (pwrite) begin
            n.cmd = pwdata[10:0];
            n.rs = {pwdata[CMD_RS_HIGH_BIT], pwdata[CMD_RS_LOW_BIT]};
            n.dout = pwdata[7:0];
            n.st = H_SETUP;
          end
        end
        HOST_STATUS_OFS: n.prdata = {16'h0, s.rd_data, 7'h0, s.st != H_IDLE};
        HOST_PIXEL_OFS: begin
          n.prdata = {22'h0, s.sync_n, s.blank_n, s.pix};
          if (pwrite) begin
            n.pix = pwdata[7:0];
            n.blank_n = pwdata[PIX_BLANK_BIT];
            n.sync_n = pwdata[PIX_SYNC_BIT];
          end
        end
        default: n.pslverr = 1'b1;
      endcase
    end
    unique case (s.st)
      H_IDLE: ;
      H_SETUP: begin
        n.oe_n = s.cmd[CMD_READ_BIT];
        n.wr_n = s.cmd[CMD_READ_BIT];
        n.rd_n = !s.cmd[CMD_READ_BIT];
        n.cnt = STROBE_CYCLES - 2'h1;
        n.st = H_STROBE;
      end
      H_STROBE: begin
        if (s.cnt == 2'h0) begin
          n.wr_n = 1'b1;
          n.rd_n = 1'b1;
          if (s.cmd[CMD_READ_BIT]) begin
            n.rd_data = link.host_data_bus;
          end
          n.st = H_HOLD;
        end else begin
          n.cnt = s.cnt - 2'h1;
        end
      end
      H_HOLD: begin
        // write data held one cycle past the rising strobe
        n.oe_n = 1'b1;
        n.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.st <= H_IDLE;
      s.wr_n <= 1'b1;
      s.rd_n <= 1'b1;
      s.oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign link.reg_select_low = s.rs[0];
  assign link.reg_select_high = s.rs[1];
  assign link.wr_n = s.wr_n;
  assign link.rd_n = s.rd_n;
  assign link.host_data_out = s.dout;
  assign link.host_data_oe_n = s.oe_n;
  assign link.pixel_index_in = s.pix;
  assign link.blank_n = s.blank_n;
  assign link.sync_n = s.sync_n;
endmodule : palette_host_end
`default_nettype wire

/* hw/palette_device_end.sv */
// device end: host register port, palette memory and edge-blend pixel path
// Function
// - select lines pick pointer, color or mask
// - three color writes store one entry
// - pointer advances after stored triple
// - three color reads, pointer advances after blue
// - pointer wraps from FF to 00
// - eight-bit mode uses all data bits
// - six-bit mode: low bits, upper read zero
// - pixel index ANDed with mask
// - latch index, blank, sync each pixel
// - reset to compatibility, sequence toggles blending
// - weighted mix of new and prior colors
// - gamma stage feeds each color output; here only while blending
// - replication samples every other pixel; here only while blending
// - four-bit systems use partial shading encoding
// - basic encoding: sixteen colors, eight mixes
// - full encoding: 223 colors, 32 mixes
// - pointer addresses all host color accesses
// - host sets mask FF when blending
// - hidden phase counter cleared on pointer write
// - pointer read changes nothing
// - holding-to-palette transfer within one cycle
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module palette_device_end (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // link
  palette_link_if.device     link,
  // color width strap, one selects eight bits
  input  wire logic          eight_bit_pin,
  // converter data
  output palette_pkg::byte_t red_out,
  output palette_pkg::byte_t green_out,
  output palette_pkg::byte_t blue_out,
  output logic               blank_out_n,
  output logic               sync_out_n,
  output logic               compatibility_mode
);
  import palette_pkg::*;

  typedef struct packed {
    logic    bits_meta;
    logic    bits_sync;
    logic    wr_n_prev;
    logic    rd_n_prev;
    logic [1:0] rs;
    byte_t   ptr;
    logic [1:0] color_phase_counter;
    byte_t   red_hold;
    byte_t   green_hold;
    entry_t  rd_hold;
    byte_t   mask;
    logic [2:0] key_cnt;
    logic    blend_en;
    logic    replicate;
    enc_t    enc;
    byte_t   dout;
    logic    oe_n;
    logic    skip;
    byte_t   pix;
    logic    pix_new;
    logic    pix_blank_n;
    logic    pix_sync_n;
    entry_t  new_c;
    entry_t  old_c;
    weight_t weight;
    logic    s2_blank_n;
    logic    s2_sync_n;
    logic    s2_blend;
    byte_t   r;
    byte_t   g;
    byte_t   b;
    logic    blank_o;
    logic    sync_o;
    logic    compat;
  } dev_state_t;

  entry_t     color_lookup_table [256];
  dev_state_t s;
  dev_state_t n;
  logic       lut_we;
  byte_t      lut_waddr;
  entry_t     lut_wdata;
  logic       eight;
  byte_t      wdat;
  byte_t      rdat;
  logic       wr_done;
  logic       rd_done;
  byte_t      idx;
  entry_t     e;

  function automatic byte_t pick_byte(input entry_t c, input logic [1:0] ph);
    unique case (ph)
      PH_RED:   pick_byte = c[23:16];
      PH_GREEN: pick_byte = c[15:8];
      default:  pick_byte = c[7:0];
    endcase
  endfunction : pick_byte

  function automatic weight_t step_weight(input logic [2:0] k);
    step_weight = {k, 2'h3};
  endfunction : step_weight

  function automatic byte_t blended_value(input byte_t nv, input byte_t ov, input weight_t w);
    logic [13:0] sum;
    sum = 14'(nv) * 14'(w) + 14'(ov) * 14'(WEIGHT_FULL - w) + MIX_ROUND;
    blended_value = 8'(sum / 14'(WEIGHT_FULL));
  endfunction : blended_value

  function automatic byte_t gamma(input byte_t x);
    if (x < GAMMA_KNEE_LO) begin
      gamma = {x[6:0], 1'b0};
    end else if (x < GAMMA_KNEE_HI) begin
      gamma = (x >> 1) + GAMMA_OFFSET;
    end else begin
      gamma = x;
    end
  endfunction : gamma

  always_comb begin
    n = s;
    lut_we = 1'b0;
    lut_waddr = s.ptr;
    n.bits_meta = eight_bit_pin;
    n.bits_sync = s.bits_meta;
    eight = s.bits_sync | s.blend_en;
    wdat = eight ? link.host_data_bus : (link.host_data_bus & SIX_BIT_MSK);
    lut_wdata = {s.red_hold, s.green_hold, wdat};
    n.wr_n_prev = link.wr_n;
    n.rd_n_prev = link.rd_n;
    wr_done = !s.wr_n_prev & link.wr_n;
    rd_done = !s.rd_n_prev & link.rd_n;
    if ((s.wr_n_prev & !link.wr_n) | (s.rd_n_prev & !link.rd_n)) begin
      n.rs = {link.reg_select_high, link.reg_select_low};
    end
    unique case ({link.reg_select_high, link.reg_select_low})
      RS_PTR_WR, RS_PTR_RD: rdat = s.ptr;
      RS_COLOR: begin
        rdat = pick_byte(s.rd_hold, s.color_phase_counter);
        if (!eight) begin
          rdat = rdat & SIX_BIT_MSK;
        end
      end
      RS_MASK: rdat = s.mask;
    endcase
    n.oe_n = link.rd_n;
    if (!link.rd_n) begin
      n.dout = rdat;
    end
    if (wr_done) begin
      n.key_cnt = 3'h0;
      unique case (s.rs)
        RS_PTR_WR, RS_PTR_RD: begin
          n.ptr = link.host_data_bus;
          n.color_phase_counter = PH_RED;
          n.rd_hold = color_lookup_table[link.host_data_bus];
        end
        RS_COLOR: begin
          unique case (s.color_phase_counter)
            PH_RED: begin
              n.red_hold = wdat;
              n.color_phase_counter = PH_GREEN;
            end
            PH_GREEN: begin
              n.green_hold = wdat;
              n.color_phase_counter = PH_BLUE;
            end
            default: begin
              lut_we = 1'b1;
              n.ptr = s.ptr + 8'h01;
              n.color_phase_counter = PH_RED;
            end
          endcase
        end
        RS_MASK: begin
          if (s.key_cnt == MODE_KEY_READS) begin
            n.blend_en = link.host_data_bus[MODE_BLEND_BIT];
            n.replicate = link.host_data_bus[MODE_REPL_BIT];
            n.enc = enc_t'(link.host_data_bus[MODE_ENC_LSB +: 2]);
          end else begin
            n.mask = link.host_data_bus;
          end
        end
      endcase
    end
    if (rd_done) begin
      n.key_cnt = 3'h0;
      unique case (s.rs)
        RS_PTR_WR, RS_PTR_RD: ;
        RS_COLOR: begin
          if (s.color_phase_counter == PH_BLUE) begin
            n.ptr = s.ptr + 8'h01;
            n.rd_hold = color_lookup_table[8'(s.ptr + 8'h01)];
            n.color_phase_counter = PH_RED;
          end else begin
            n.color_phase_counter = s.color_phase_counter + 2'h1;
          end
        end
        RS_MASK: begin
          if (s.key_cnt != MODE_KEY_READS) begin
            n.key_cnt = s.key_cnt + 3'h1;
          end else begin
            n.key_cnt = s.key_cnt;
          end
        end
      endcase
    end
    n.skip = (s.replicate & s.blend_en) ? !s.skip : 1'b0;
    n.pix_new = !s.skip;
    if (!s.skip) begin
      n.pix = link.pixel_index_in;
      n.pix_blank_n = link.blank_n;
      n.pix_sync_n = link.sync_n;
    end
    idx = s.pix & s.mask;
    e = color_lookup_table[idx];
    if (s.pix_new) begin
      n.s2_blank_n = s.pix_blank_n;
      n.s2_sync_n = s.pix_sync_n;
      n.s2_blend = s.blend_en;
      if (!s.blend_en) begin
        n.new_c = e;
        n.weight = WEIGHT_FULL;
      end else begin
        unique case (s.enc)
          ENC_BASIC8: begin
            if (idx[7:4] == 4'h0) begin
              n.new_c = e;
              n.weight = WEIGHT_FULL;
            end else if (idx[7:4] == 4'h1 && !idx[3]) begin
              n.weight = step_weight(idx[2:0]);
            end else if (idx[7:4] == 4'h2) begin
              n.old_c = color_lookup_table[{4'h0, idx[3:0]}];
            end
          end
          ENC_ADV4: begin
            if (idx[3]) begin
              n.weight = step_weight(idx[2:0]);
            end else begin
              n.old_c = s.new_c;
              n.new_c = color_lookup_table[{5'h00, idx[2:0]}];
              n.weight = WEIGHT_FULL;
            end
          end
          ENC_ADV8: begin
            if (idx < ADV8_CMD_IDX) begin
              n.old_c = s.new_c;
              n.new_c = e;
              n.weight = WEIGHT_FULL;
            end else if (idx >= ADV8_MIX_BASE) begin
              n.weight = 5'(idx - ADV8_MIX_BASE);
            end
          end
          default: ;
        endcase
      end
    end
    n.blank_o = s.s2_blank_n;
    n.sync_o = s.s2_sync_n;
    n.compat = !n.blend_en;
    if (!s.s2_blank_n) begin
      n.r = 8'h00;
      n.g = 8'h00;
      n.b = 8'h00;
    end else if (s.s2_blend) begin
      n.r = gamma(blended_value(s.new_c[23:16], s.old_c[23:16], s.weight));
      n.g = gamma(blended_value(s.new_c[15:8], s.old_c[15:8], s.weight));
      n.b = gamma(blended_value(s.new_c[7:0], s.old_c[7:0], s.weight));
    end else begin
      n.r = s.new_c[23:16];
      n.g = s.new_c[15:8];
      n.b = s.new_c[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.enc <= ENC_BASIC8;
      s.ptr <= PTR_RESET;
      s.mask <= MASK_RESET;
      s.oe_n <= 1'b1;
      s.wr_n_prev <= 1'b1;
      s.rd_n_prev <= 1'b1;
      s.weight <= WEIGHT_FULL;
      s.compat <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge clock) begin
    if (lut_we) begin
      color_lookup_table[lut_waddr] <= lut_wdata;
    end
  end

  assign red_out = s.r;
  assign green_out = s.g;
  assign blue_out = s.b;
  assign blank_out_n = s.blank_o;
  assign sync_out_n = s.sync_o;
  assign compatibility_mode = s.compat;
  assign link.dev_data_out = s.dout;
  assign link.dev_data_oe_n = s.oe_n;
endmodule : palette_device_end
`default_nettype wire

/* verification/palette_link_monitor.sv */
// concurrent checks on the link between host end and device end
`timescale 1ns/100ps
`default_nettype none
module palette_link_monitor (
  // clock and reset
  input wire logic       clock,
  input wire logic       rst,
  // link signals
  input wire logic       reg_select_low,
  input wire logic       reg_select_high,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] host_data_out,
  input wire logic       host_data_oe_n,
  input wire logic       dev_data_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_strobe_exclusive: assert property (wr_n || rd_n)
    else $error("write and read strobes low together");
  a_select_held: assert property (!(wr_n && rd_n) |-> $stable({reg_select_high, reg_select_low}))
    else $error("select lines moved during a strobe");
  a_wr_strobe_len: assert property ($fell(wr_n) |-> !wr_n ##1 !wr_n ##1 wr_n)
    else $error("write strobe not two cycles");
  a_rd_strobe_len: assert property ($fell(rd_n) |-> !rd_n ##1 !rd_n ##1 rd_n)
    else $error("read strobe not two cycles");
  a_wdata_held: assert property (!wr_n |-> !host_data_oe_n && $stable(host_data_out))
    else $error("write data not held through strobe");
  a_wr_hold_release: assert property ($rose(wr_n) |-> !host_data_oe_n ##1 host_data_oe_n)
    else $error("write data hold cycle wrong");
  a_dev_drive_start: assert property ($fell(rd_n) |=> $fell(dev_data_oe_n))
    else $error("device drive did not start one cycle after read strobe");
  a_dev_drive_stop: assert property ($rose(rd_n) |=> $rose(dev_data_oe_n))
    else $error("device drive did not stop one cycle after read strobe");
  a_host_quiet_read: assert property (!rd_n |-> host_data_oe_n)
    else $error("host drives bus during read");
  a_no_contention: assert property (dev_data_oe_n || host_data_oe_n)
    else $error("both ends drive the data bus");

  c_color_write: cover property ($fell(wr_n) && {reg_select_high, reg_select_low} == 2'h1);
  c_color_read: cover property ($fell(rd_n) && {reg_select_high, reg_select_low} == 2'h1);
  c_mask_write: cover property ($fell(wr_n) && {reg_select_high, reg_select_low} == 2'h2);
endmodule : palette_link_monitor
`default_nettype wire

/* verification/tb_top.sv */
// bench: host end and device end joined by the palette link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import palette_pkg::*;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        eight_bit_pin = 1'b1;
  byte_t       red_out;
  byte_t       green_out;
  byte_t       blue_out;
  logic        blank_out_n;
  logic        sync_out_n;
  logic        compatibility_mode;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [31:0] rd;
  logic        err;
  byte_t       pal [6] = '{8'h11, 8'h22, 8'h33, 8'hA4, 8'h5B, 8'hC6};
  byte_t       six [6] = '{8'hC5, 8'hFF, 8'h80, 8'h05, 8'h3F, 8'h00};
  byte_t       mix [6] = '{8'hF0, 8'h60, 8'h20, 8'h10, 8'hA0, 8'hFF};

  always #12.5 clock = ~clock;

  palette_link_if link ();
  palette_host_end palette_host_end_i (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  palette_device_end palette_device_end_i (.clock(clock), .rst(rst), .link(link), .eight_bit_pin(eight_bit_pin),
    .red_out(red_out), .green_out(green_out), .blue_out(blue_out), .blank_out_n(blank_out_n),
    .sync_out_n(sync_out_n), .compatibility_mode(compatibility_mode));
  palette_link_monitor palette_link_monitor_i (.clock(clock), .rst(rst), .reg_select_low(link.reg_select_low),
    .reg_select_high(link.reg_select_high), .wr_n(link.wr_n), .rd_n(link.rd_n), .host_data_out(link.host_data_out),
    .host_data_oe_n(link.host_data_oe_n), .dev_data_oe_n(link.dev_data_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one link cycle; read byte lands in rd[15:8]
  task automatic cmd(input logic [1:0] rs, input logic rdb, input byte_t d);
    apb(1'b1, HOST_CMD_OFS, {21'h0, rdb, rs, d});
    do apb(1'b0, HOST_STATUS_OFS, 32'h0); while (rd[0] !== 1'b0);
  endtask : cmd

  task automatic mode_key(input byte_t m);
    for (int i = 0; i < 4; i++) cmd(RS_MASK, 1'b1, 8'h00);
    cmd(RS_MASK, 1'b0, m);
  endtask : mode_key

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    check(32'(compatibility_mode), 32'h1);
    cmd(RS_MASK, 1'b1, 8'h00);
    check(32'(rd[15:8]), 32'(MASK_RESET));
    apb(1'b0, 12'h00C, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    // two triples across the last entry, then wrap
    cmd(RS_PTR_WR, 1'b0, 8'hFE);
    for (int i = 0; i < 6; i++) cmd(RS_COLOR, 1'b0, pal[i]);
    cmd(RS_PTR_RD, 1'b1, 8'h00);
    check(32'(rd[15:8]), 32'h00);
    cmd(RS_PTR_RD, 1'b0, 8'hFE);
    for (int i = 0; i < 6; i++) begin
      cmd(RS_COLOR, 1'b1, 8'h00);
      check(32'(rd[15:8]), 32'(pal[i]));
      if (i == 0) begin
        cmd(RS_PTR_WR, 1'b1, 8'h00);
        check(32'(rd[15:8]), 32'hFE);
      end
    end
    // partial triple discarded by a pointer write
    cmd(RS_PTR_WR, 1'b0, 8'h10);
    cmd(RS_COLOR, 1'b0, 8'h77);
    cmd(RS_PTR_WR, 1'b0, 8'h10);
    for (int i = 0; i < 3; i++) cmd(RS_COLOR, 1'b0, 8'hAA + 8'(i * 17));
    cmd(RS_PTR_RD, 1'b0, 8'h10);
    for (int i = 0; i < 3; i++) begin
      cmd(RS_COLOR, 1'b1, 8'h00);
      check(32'(rd[15:8]), 32'(8'hAA + 8'(i * 17)));
    end
    cmd(RS_MASK, 1'b0, 8'h1F);
    cmd(RS_MASK, 1'b1, 8'h00);
    check(32'(rd[15:8]), 32'h1F);
    // masked pixel index F0 selects entry 10
    apb(1'b1, HOST_PIXEL_OFS, 32'h3F0);
    repeat (8) @(posedge clock);
    check({6'h0, blank_out_n, sync_out_n, red_out, green_out, blue_out}, 32'h03AABBCC);
    apb(1'b1, HOST_PIXEL_OFS, 32'h2F0);
    repeat (8) @(posedge clock);
    check({6'h0, blank_out_n, sync_out_n, red_out, green_out, blue_out}, 32'h01000000);
    // six-bit color data
    eight_bit_pin <= 1'b0;
    cmd(RS_PTR_WR, 1'b0, 8'h20);
    for (int i = 0; i < 3; i++) cmd(RS_COLOR, 1'b0, six[i]);
    cmd(RS_PTR_RD, 1'b0, 8'h20);
    for (int i = 0; i < 3; i++) begin
      cmd(RS_COLOR, 1'b1, 8'h00);
      check(32'(rd[15:8]), 32'(six[i + 3]));
    end
    eight_bit_pin <= 1'b1;
    // blend on, mask kept, then mask set to FF
    mode_key(8'h01);
    check(32'(compatibility_mode), 32'h0);
    cmd(RS_MASK, 1'b1, 8'h00);
    check(32'(rd[15:8]), 32'h1F);
    cmd(RS_MASK, 1'b0, 8'hFF);
    // entry 01 new color, entry 02 prior color
    cmd(RS_PTR_WR, 1'b0, 8'h01);
    for (int i = 0; i < 6; i++) cmd(RS_COLOR, 1'b0, mix[i]);
    // basic encoding: load prior, load new, then weight step 3 (15)
    apb(1'b1, HOST_PIXEL_OFS, 32'h322);
    repeat (4) @(posedge clock);
    apb(1'b1, HOST_PIXEL_OFS, 32'h301);
    repeat (8) @(posedge clock);
    check({6'h0, blank_out_n, sync_out_n, red_out, green_out, blue_out}, 32'h03F09040);
    apb(1'b1, HOST_PIXEL_OFS, 32'h313);
    repeat (8) @(posedge clock);
    check({6'h0, blank_out_n, sync_out_n, red_out, green_out, blue_out}, 32'h039EA0A9);
    // full encoding: color 01 held, then half-weight mix of equal colors
    mode_key(8'h09);
    apb(1'b1, HOST_PIXEL_OFS, 32'h301);
    repeat (4) @(posedge clock);
    apb(1'b1, HOST_PIXEL_OFS, 32'h3F0);
    repeat (8) @(posedge clock);
    check({6'h0, blank_out_n, sync_out_n, red_out, green_out, blue_out}, 32'h03F09040);
    mode_key(8'h00);
    check(32'(compatibility_mode), 32'h1);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
